// ---- cbiu_mem_model.sv ----
/* cbiu_mem_model: memory on the far side of cbiu_top; reads give the
   inverted address, address nibble F faults. Assumes one clock. */
`timescale 1ns/1ps
module cbiu_mem_model
	import cbiu_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// bus cycle and wait states
	input  wire logic        ext_valid,
	input  wire cbiu_ext_t   ext_cmd,
	input  wire logic [1:0]  ws,
	// answer
	output logic             ext_ready,
	output logic [31:0]      ext_rdata,
	output logic             memory_exception_n
);
	logic [1:0] wait_r;

	// counts wait states, then answers for one cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_ready <= 1'b0;
			wait_r <= 2'h0;
			ext_rdata <= 32'h0;
			memory_exception_n <= 1'b1;
		end else if (ext_valid && !ext_ready && wait_r >= ws) begin
			ext_ready <= 1'b1;
			ext_rdata <= ~ext_cmd.addr;
			memory_exception_n <= ext_cmd.addr[31:28] != 4'hF;
		end else begin
			ext_ready <= 1'b0;
			wait_r <= (ext_valid && !ext_ready) ? wait_r + 2'h1 : 2'h0;
			ext_rdata <= ~ext_rdata; // idle lines toggle
			memory_exception_n <= 1'b1;
		end
	end
endmodule

// ---- cbiu_pkg.sv ----
/*
 * cbiu_pkg: constants, register map and carrier types of the cache and bus
 * interface unit. Assumes nothing beyond a SystemVerilog compiler.
 */
package cbiu_pkg;

	// cache geometry
	localparam int CBIU_SETS        = 64;
	localparam int CBIU_WAYS        = 2;
	localparam int CBIU_LINE_BYTES  = 16;
	localparam int CBIU_LINE_WORDS  = 4;

	// register byte offsets on the control bus
	localparam logic [7:0] CBIU_OFS_CTRL      = 8'h00;
	localparam logic [7:0] CBIU_OFS_STATUS    = 8'h04;
	localparam logic [7:0] CBIU_OFS_FAIL_ADDR = 8'h08;
	localparam logic [7:0] CBIU_OFS_FAIL_DATA = 8'h0C;

	// control register fields and reset value
	localparam int          CBIU_CTRL_ICACHE_BIT = 0;
	localparam int          CBIU_CTRL_DCACHE_BIT = 1;
	localparam int          CBIU_CTRL_WBUF_BIT   = 5;
	localparam logic [31:0] CBIU_CTRL_MASK       = 32'h0000_0023;
	localparam logic [31:0] CBIU_CTRL_RESET      = 32'h0000_0000;

	// status register fields
	localparam int CBIU_STAT_WBERR_BIT  = 0;
	localparam int CBIU_STAT_WBFULL_BIT = 1;
	localparam int CBIU_STAT_PFFULL_BIT = 2;

	// bus responses
	localparam logic [1:0] CBIU_RESP_OKAY   = 2'h0;
	localparam logic [1:0] CBIU_RESP_DECERR = 2'h3;

	// kind of external bus cycle in progress
	typedef enum logic [1:0] {
		CBIU_BK_WBUF,
		CBIU_BK_DATA,
		CBIU_BK_IFETCH,
		CBIU_BK_PFETCH
	} cbiu_kind_t;

	// external bus cycle request
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0]  be;
		logic        write;
		logic        instr;
	} cbiu_ext_t;

	// data request from the integer core
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0]  be;
		logic        write;
	} cbiu_dreq_t;

	// response to the integer core
	typedef struct packed {
		logic        valid;
		logic [31:0] data;
		logic        exc;
	} cbiu_rsp_t;

endpackage

// ---- cbiu_top.sv ----
/*
 * cbiu_top: instruction and data caches with the bus interface unit, one
 * posted write buffer, one sequential prefetch buffer, exception forwarding
 * and an AXI4-Lite control slave.
 * Assumes the external bus and the integer core run on aclk; external bus
 * inputs are synchronous to aclk.
 */
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps

module cbiu_top
	import cbiu_pkg::*;
#(
	parameter int SETS = CBIU_SETS
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// control register slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// instruction port of the integer core
	input  wire logic        i_req,
	input  wire logic [31:0] i_addr,
	output logic             i_gnt,
	output cbiu_rsp_t        i_rsp,
	// data port of the integer core
	input  wire logic        d_req,
	input  wire cbiu_dreq_t  d_cmd,
	output logic             d_gnt,
	output cbiu_rsp_t        d_rsp,
	output logic             d_post_exc,
	// external memory and io bus
	output logic             ext_valid,
	output cbiu_ext_t        ext_cmd,
	input  wire logic        ext_ready,
	input  wire logic [31:0] ext_rdata,
	input  wire logic        memory_exception_n,
	input  wire logic        ext_breq,
	output logic             ext_bgnt
);

	localparam int IW = $clog2(SETS);
	localparam int TW = 28 - IW;

	// geometry check
	if (SETS < 2 || (1 << IW) != SETS || CBIU_WAYS != 2) begin : g_bad_geometry
		$error("cbiu_top: SETS must be a power of two, ways must be two");
	end

	typedef enum logic [1:0] {PF_OFF, PF_ARMED, PF_BUSY, PF_FULL} cbiu_pf_t;

	// register decode shared by read and write paths
	function automatic logic reg_mapped(input logic [7:0] a);
		return a == CBIU_OFS_CTRL || a == CBIU_OFS_STATUS ||
			a == CBIU_OFS_FAIL_ADDR || a == CBIU_OFS_FAIL_DATA;
	endfunction

	// tag compare with any word of the line present
	function automatic logic tag_match(input logic [TW-1:0] t, input logic [3:0] v,
		input logic [TW-1:0] a);
		return t == a && |v;
	endfunction

	// control state
	logic [31:0] ctrl_r, ctrl_nxt;
	logic        wberr_r, wberr_nxt;
	logic [31:0] fail_addr_r, fail_addr_nxt, fail_data_r, fail_data_nxt;
	logic        aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
	logic [7:0]  awaddr_r, awaddr_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic [3:0]  wstrb_r, wstrb_nxt;
	logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	// bus, buffers and responses
	logic        ext_valid_r, ext_valid_nxt, bgnt_r, bgnt_nxt;
	cbiu_ext_t   ext_cmd_r, ext_cmd_nxt, wb_cmd_r, wb_cmd_nxt;
	cbiu_kind_t  kind_r, kind_nxt;
	logic        wb_full_r, wb_full_nxt;
	cbiu_pf_t    pf_st_r, pf_st_nxt;
	logic [31:0] pf_addr_r, pf_addr_nxt, pf_data_r, pf_data_nxt;
	logic        pf_exc_r, pf_exc_nxt;
	cbiu_rsp_t   i_rsp_r, i_rsp_nxt, d_rsp_r, d_rsp_nxt;
	logic        post_exc_r, post_exc_nxt;
	// cache ports, index 0 instruction, 1 data
	logic [31:0] lk_addr [2];
	logic        c_hit [2];
	logic [31:0] c_rdata [2];
	logic        fill_en [2];
	logic [31:0] fill_data [2];
	logic        st_en [2];
	// decoded conditions
	logic ic_on, dc_on, post_ok, i_hit, d_hit, bus_idle, bus_done, bus_exc;
	logic done_if, done_pf, done_data, done_wb, pf_match, pf_serve, i_miss, d_need;
	logic issue, aw_take, w_take, do_wr, ar_take;
	logic [7:0] wr_addr;

	// caches: per-word valid bits, byte write lanes, fill victim toggle
	for (genvar c = 0; c < 2; c++) begin : g_cache
		logic [31:0]   mem_r [CBIU_WAYS][SETS*CBIU_LINE_WORDS];
		logic [TW-1:0] tag_r [CBIU_WAYS][SETS];
		logic [3:0]    vld_r [CBIU_WAYS][SETS];
		logic [SETS-1:0] vict_r;
		logic [IW-1:0] idx;
		logic [1:0]    wd;
		logic [TW-1:0] atag;
		logic [1:0]    way_tag, way_hit;
		logic          hit_way, fill_way;

		// lookup of the addressed word in both banks
		always_comb begin
			idx  = lk_addr[c][4 +: IW];
			wd   = lk_addr[c][3:2];
			atag = lk_addr[c][31 -: TW];
			for (int w = 0; w < CBIU_WAYS; w++) begin
				way_tag[w] = tag_match(tag_r[w][idx], vld_r[w][idx], atag);
				way_hit[w] = way_tag[w] && vld_r[w][idx][wd];
			end
			hit_way  = way_hit[1];
			fill_way = way_tag[0] ? 1'b0 : (way_tag[1] ? 1'b1 : vict_r[idx]);
		end
		assign c_hit[c]   = |way_hit;
		assign c_rdata[c] = mem_r[hit_way][{idx, wd}];

		// tag and valid state; a new tag keeps only the refilled word valid
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				for (int w = 0; w < CBIU_WAYS; w++) begin
					for (int s = 0; s < SETS; s++) begin
						vld_r[w][s] <= 4'h0;
					end
				end
				vict_r <= '0;
			end else if (fill_en[c]) begin
				if (way_tag[fill_way]) begin
					vld_r[fill_way][idx][wd] <= 1'b1;
				end else begin
					tag_r[fill_way][idx] <= atag;
					vld_r[fill_way][idx] <= 4'(1 << wd);
					vict_r[idx]          <= ~fill_way;
				end
			end
		end

		// word refill and byte-lane store writes
		always_ff @(posedge aclk) begin
			if (fill_en[c]) begin
				mem_r[fill_way][{idx, wd}] <= fill_data[c];
			end else if (st_en[c]) begin
				for (int b = 0; b < 4; b++) begin
					if (d_cmd.be[b]) begin
						mem_r[hit_way][{idx, wd}][8*b +: 8] <= d_cmd.wdata[8*b +: 8];
					end
				end
			end
		end
	end

	// independent lookups for both caches every cycle
	assign lk_addr[0] = i_addr;
	assign lk_addr[1] = d_cmd.addr;

	// mode, hit and bus completion decode
	always_comb begin
		ic_on     = ctrl_r[CBIU_CTRL_ICACHE_BIT];
		dc_on     = ctrl_r[CBIU_CTRL_DCACHE_BIT];
		post_ok   = ctrl_r[CBIU_CTRL_WBUF_BIT] && ic_on && dc_on;
		i_hit     = ic_on && c_hit[0];
		d_hit     = dc_on && c_hit[1];
		bus_idle  = !ext_valid_r;
		bus_done  = ext_valid_r && ext_ready;
		bus_exc   = bus_done && !memory_exception_n;
		done_if   = bus_done && kind_r == CBIU_BK_IFETCH;
		done_pf   = bus_done && kind_r == CBIU_BK_PFETCH;
		done_data = bus_done && kind_r == CBIU_BK_DATA;
		done_wb   = bus_done && kind_r == CBIU_BK_WBUF;
		pf_match  = pf_st_r == PF_FULL && i_addr[31:2] == pf_addr_r[31:2];
		pf_serve  = i_req && pf_match && !i_hit;
		i_miss    = i_req && !i_hit && !pf_match;
		d_need    = d_req && (d_cmd.write ? !post_ok : !d_hit);
		// grants: hits, posted stores, buffered prefetch or finished bus cycle
		i_gnt     = i_req && (i_hit || pf_serve || done_if);
		d_gnt     = d_req && (d_cmd.write ? (post_ok ? !wb_full_r : done_data)
			: (d_hit || done_data));
		issue     = bus_idle && !ext_breq && (wb_full_r || d_need || i_miss ||
			(pf_st_r == PF_ARMED && ic_on));
	end

	// cache write controls; returned data goes to cache and core together
	always_comb begin
		fill_en[0]   = (done_if && ic_on && !bus_exc) || (pf_serve && !pf_exc_r);
		fill_data[0] = pf_serve ? pf_data_r : ext_rdata;
		fill_en[1]   = done_data && !d_cmd.write && dc_on && !bus_exc;
		fill_data[1] = ext_rdata;
		st_en[0]     = 1'b0;
		st_en[1]     = d_gnt && d_cmd.write && d_hit;
	end

	// bus arbitration, write buffer, prefetch buffer and core responses
	always_comb begin
		ext_valid_nxt = ext_valid_r;
		ext_cmd_nxt   = ext_cmd_r;
		kind_nxt      = kind_r;
		wb_full_nxt   = wb_full_r;
		wb_cmd_nxt    = wb_cmd_r;
		pf_st_nxt     = pf_st_r;
		pf_addr_nxt   = pf_addr_r;
		pf_data_nxt   = pf_data_r;
		pf_exc_nxt    = pf_exc_r;
		bgnt_nxt      = ext_breq && (bus_idle || bus_done);
		if (bus_done) begin
			ext_valid_nxt = 1'b0;
		end
		// fixed priority once the bus is free
		if (issue) begin
			ext_valid_nxt = 1'b1;
			if (wb_full_r) begin
				kind_nxt    = CBIU_BK_WBUF;
				ext_cmd_nxt = wb_cmd_r;
				wb_full_nxt = 1'b0;
			end else if (d_need) begin
				kind_nxt    = CBIU_BK_DATA;
				ext_cmd_nxt = '{addr: d_cmd.addr, wdata: d_cmd.wdata,
					be: d_cmd.write ? d_cmd.be : 4'hF, write: d_cmd.write, instr: 1'b0};
			end else if (i_miss) begin
				kind_nxt    = CBIU_BK_IFETCH;
				ext_cmd_nxt = '{addr: {i_addr[31:2], 2'h0}, wdata: 32'h0,
					be: 4'hF, write: 1'b0, instr: 1'b1};
			end else begin
				kind_nxt    = CBIU_BK_PFETCH;
				ext_cmd_nxt = '{addr: pf_addr_r, wdata: 32'h0,
					be: 4'hF, write: 1'b0, instr: 1'b1};
			end
		end
		// posted store capture
		if (d_gnt && d_cmd.write && post_ok) begin
			wb_full_nxt = 1'b1;
			wb_cmd_nxt  = '{addr: d_cmd.addr, wdata: d_cmd.wdata, be: d_cmd.be,
				write: 1'b1, instr: 1'b0};
		end
		// prefetch buffer
		case (pf_st_r)
			PF_OFF: begin
				pf_st_nxt = PF_OFF;
			end
			PF_ARMED: begin
				if (issue && !wb_full_r && !d_need && !i_miss) begin
					pf_st_nxt = PF_BUSY;
				end else if (i_req && i_hit && i_addr[31:2] == pf_addr_r[31:2]) begin
					pf_addr_nxt = pf_addr_r + 32'h4;                     // skip a word already cached
				end
			end
			PF_BUSY: begin
				if (done_pf) begin
					pf_st_nxt   = PF_FULL;
					pf_data_nxt = ext_rdata;
					pf_exc_nxt  = bus_exc;
				end
			end
			PF_FULL: begin
				if (pf_serve) begin
					pf_st_nxt   = PF_ARMED;
					pf_addr_nxt = pf_addr_r + 32'h4;
				end else if (i_req && (pf_match || i_miss)) begin
					pf_st_nxt = PF_OFF;
				end
			end
			default: begin
				pf_st_nxt = PF_OFF;
			end
		endcase
		if (done_if) begin
			pf_st_nxt   = PF_ARMED;
			pf_addr_nxt = ext_cmd_r.addr + 32'h4;
		end
		if (!ic_on) begin
			pf_st_nxt = PF_OFF;
		end
		// registered responses, exceptions forwarded with the data
		i_rsp_nxt.valid = i_gnt;
		i_rsp_nxt.data  = done_if ? ext_rdata : (pf_serve ? pf_data_r : c_rdata[0]);
		i_rsp_nxt.exc   = done_if ? bus_exc : (pf_serve && pf_exc_r);
		d_rsp_nxt.valid = d_gnt;
		d_rsp_nxt.data  = done_data ? ext_rdata : c_rdata[1];
		d_rsp_nxt.exc   = done_data && bus_exc;
		post_exc_nxt    = done_wb && bus_exc;
	end

	// control register slave
	always_comb begin
		ctrl_nxt      = ctrl_r;
		wberr_nxt     = wberr_r;
		fail_addr_nxt = fail_addr_r;
		fail_data_nxt = fail_data_r;
		aw_take       = s_axi_awvalid && s_axi_awready;
		w_take        = s_axi_wvalid && s_axi_wready;
		aw_got_nxt    = aw_got_r || aw_take;
		w_got_nxt     = w_got_r || w_take;
		awaddr_nxt    = aw_take ? s_axi_awaddr : awaddr_r;
		wdata_nxt     = w_take ? s_axi_wdata : wdata_r;
		wstrb_nxt     = w_take ? s_axi_wstrb : wstrb_r;
		wr_addr       = aw_got_r ? awaddr_r : s_axi_awaddr;
		do_wr         = aw_got_nxt && w_got_nxt && !bvalid_r;
		bvalid_nxt    = bvalid_r && !s_axi_bready;
		bresp_nxt     = bresp_r;
		if (do_wr) begin
			aw_got_nxt = 1'b0;
			w_got_nxt  = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt  = reg_mapped(wr_addr) ? CBIU_RESP_OKAY : CBIU_RESP_DECERR;
			if (wr_addr == CBIU_OFS_CTRL && wstrb_nxt[0]) begin
				ctrl_nxt = wdata_nxt & CBIU_CTRL_MASK;
			end
			if (wr_addr == CBIU_OFS_STATUS && wstrb_nxt[0] && wdata_nxt[CBIU_STAT_WBERR_BIT]) begin
				wberr_nxt = 1'b0;
			end
		end
		// failed posted write capture; the set wins over a clear
		if (done_wb && bus_exc) begin
			wberr_nxt     = 1'b1;
			fail_addr_nxt = ext_cmd_r.addr;
			fail_data_nxt = ext_cmd_r.wdata;
		end
		// reads
		ar_take    = s_axi_arvalid && s_axi_arready;
		rvalid_nxt = rvalid_r && !s_axi_rready;
		rdata_nxt  = rdata_r;
		rresp_nxt  = rresp_r;
		if (ar_take) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = reg_mapped(s_axi_araddr) ? CBIU_RESP_OKAY : CBIU_RESP_DECERR;
			case (s_axi_araddr)
				CBIU_OFS_CTRL:      rdata_nxt = ctrl_r;
				CBIU_OFS_STATUS:    rdata_nxt = {29'h0, pf_st_r == PF_FULL, wb_full_r, wberr_r};
				CBIU_OFS_FAIL_ADDR: rdata_nxt = fail_addr_r;
				CBIU_OFS_FAIL_DATA: rdata_nxt = fail_data_r;
				default:            rdata_nxt = 32'h0;
			endcase
		end
	end

	// state registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r      <= CBIU_CTRL_RESET;
			wberr_r     <= 1'b0;
			fail_addr_r <= 32'h0;
			fail_data_r <= 32'h0;
			aw_got_r    <= 1'b0;
			w_got_r     <= 1'b0;
			awaddr_r    <= 8'h0;
			wdata_r     <= 32'h0;
			wstrb_r     <= 4'h0;
			bvalid_r    <= 1'b0;
			bresp_r     <= CBIU_RESP_OKAY;
			rvalid_r    <= 1'b0;
			rresp_r     <= CBIU_RESP_OKAY;
			rdata_r     <= 32'h0;
			ext_valid_r <= 1'b0;
			ext_cmd_r   <= '0;
			kind_r      <= CBIU_BK_WBUF;
			bgnt_r      <= 1'b0;
			wb_full_r   <= 1'b0;
			wb_cmd_r    <= '0;
			pf_st_r     <= PF_OFF;
			pf_addr_r   <= 32'h0;
			pf_data_r   <= 32'h0;
			pf_exc_r    <= 1'b0;
			i_rsp_r     <= '0;
			d_rsp_r     <= '0;
			post_exc_r  <= 1'b0;
		end else begin
			ctrl_r      <= ctrl_nxt;
			wberr_r     <= wberr_nxt;
			fail_addr_r <= fail_addr_nxt;
			fail_data_r <= fail_data_nxt;
			aw_got_r    <= aw_got_nxt;
			w_got_r     <= w_got_nxt;
			awaddr_r    <= awaddr_nxt;
			wdata_r     <= wdata_nxt;
			wstrb_r     <= wstrb_nxt;
			bvalid_r    <= bvalid_nxt;
			bresp_r     <= bresp_nxt;
			rvalid_r    <= rvalid_nxt;
			rresp_r     <= rresp_nxt;
			rdata_r     <= rdata_nxt;
			ext_valid_r <= ext_valid_nxt;
			ext_cmd_r   <= ext_cmd_nxt;
			kind_r      <= kind_nxt;
			bgnt_r      <= bgnt_nxt;
			wb_full_r   <= wb_full_nxt;
			wb_cmd_r    <= wb_cmd_nxt;
			pf_st_r     <= pf_st_nxt;
			pf_addr_r   <= pf_addr_nxt;
			pf_data_r   <= pf_data_nxt;
			pf_exc_r    <= pf_exc_nxt;
			i_rsp_r     <= i_rsp_nxt;
			d_rsp_r     <= d_rsp_nxt;
			post_exc_r  <= post_exc_nxt;
		end
	end

	// outputs
	assign s_axi_awready = !aw_got_r && !bvalid_r;
	assign s_axi_wready  = !w_got_r && !bvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;
	assign ext_valid     = ext_valid_r;
	assign ext_cmd       = ext_cmd_r;
	assign ext_bgnt      = bgnt_r;
	assign i_rsp         = i_rsp_r;
	assign d_rsp         = d_rsp_r;
	assign d_post_exc    = post_exc_r;

endmodule

// ---- cbiu_top_asserts.sv ----
/* cbiu_top_asserts: port checks for cbiu_top.
   Assumes one clock domain; bound into every cbiu_top. */
`timescale 1ns/1ps
module cbiu_top_asserts
	import cbiu_pkg::*;
#(
	parameter int SETS = CBIU_SETS
) (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// core ports
	input wire logic        i_req,
	input wire logic [31:0] i_addr,
	input wire logic        i_gnt,
	input wire cbiu_rsp_t   i_rsp,
	input wire logic        d_req,
	input wire cbiu_dreq_t  d_cmd,
	input wire logic        d_gnt,
	input wire cbiu_rsp_t   d_rsp,
	input wire logic        d_post_exc,
	// external bus
	input wire logic        ext_valid,
	input wire cbiu_ext_t   ext_cmd,
	input wire logic        ext_ready,
	input wire logic [31:0] ext_rdata,
	input wire logic        memory_exception_n,
	input wire logic        ext_breq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// end of an instruction or data read on the bus
	sequence s_iend;
		ext_valid && ext_ready && ext_cmd.instr && !ext_cmd.write;
	endsequence
	sequence s_dend;
		ext_valid && ext_ready && !ext_cmd.instr && !ext_cmd.write;
	endsequence

	// bus cycle shape and issue
	a_ext_hold: assert property (
		ext_valid && !ext_ready |=> ext_valid && $stable(ext_cmd))
		else $error("bus cycle changed before ready");
	a_ext_gap: assert property (ext_valid && ext_ready |=> !ext_valid)
		else $error("no idle cycle after a transfer");
	a_miss_issue: assert property (
		(i_req && !i_gnt || d_req && !d_gnt) && !ext_valid && !ext_breq |=> ext_valid)
		else $error("miss not issued in the next cycle");
	a_breq_block: assert property ($rose(ext_valid) |-> !$past(ext_breq))
		else $error("bus cycle issued while another master asked");
	// answers to the core
	a_irsp_next: assert property (i_req && i_gnt |=> i_rsp.valid)
		else $error("instruction answer missing");
	a_ifetch_data: assert property (
		s_iend ##0 (i_req && i_gnt && ext_cmd.addr[31:2] == i_addr[31:2]) |=>
		i_rsp.data == $past(ext_rdata) && i_rsp.exc == !$past(memory_exception_n))
		else $error("fetch data or exception lost");
	a_dfetch_exc: assert property (
		s_dend ##0 (d_req && d_gnt && !d_cmd.write && ext_cmd.addr[31:2] == d_cmd.addr[31:2])
		|=> d_rsp.exc == !$past(memory_exception_n))
		else $error("data fetch exception lost");
	a_post_fail: assert property (d_post_exc |-> $past(ext_valid) && $past(ext_ready) &&
		$past(ext_cmd.write) && !$past(memory_exception_n))
		else $error("posted fault without a failed write");
endmodule
bind cbiu_top cbiu_top_asserts #(.SETS(SETS)) u_asserts (.aclk, .aresetn, .i_req, .i_addr,
	.i_gnt, .i_rsp, .d_req, .d_cmd, .d_gnt, .d_rsp, .d_post_exc, .ext_valid, .ext_cmd,
	.ext_ready, .ext_rdata, .memory_exception_n, .ext_breq);

// ---- tb.sv ----
/* tb: self-checking bench for cbiu_top.
   Assumes cbiu_mem_model and the bound checker are compiled. */
`timescale 1ns/1ps
module tb
	import cbiu_pkg::*;
;
	localparam logic [31:0] ia = 32'h100, ib = 32'h140, ic = 32'h200;
	localparam logic [31:0] da = 32'h400, fa = 32'hF0000000;
	localparam logic [1:0]  ok = CBIU_RESP_OKAY, de = CBIU_RESP_DECERR;
	logic        aclk, aresetn, i_req, i_gnt, d_req, d_gnt, d_post_exc, ext_valid;
	logic        ext_ready, memory_exception_n, ext_breq, ext_bgnt;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, ws;
	logic [31:0] s_axi_wdata, s_axi_rdata, i_addr, ext_rdata, wd_seen, a;
	cbiu_rsp_t   i_rsp, d_rsp, rsp;
	cbiu_dreq_t  d_cmd;
	cbiu_ext_t   ext_cmd;
	int          fails, samples_checked, waited, seed, n;

	// design, far side, clock
	cbiu_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .i_req, .i_addr,
		.i_gnt, .i_rsp, .d_req, .d_cmd, .d_gnt, .d_rsp, .d_post_exc, .ext_valid,
		.ext_cmd, .ext_ready, .ext_rdata, .memory_exception_n, .ext_breq, .ext_bgnt);
	cbiu_mem_model mem (.aclk, .aresetn, .ext_valid, .ext_cmd, .ws, .ext_ready,
		.ext_rdata, .memory_exception_n);
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	// verdict, comparison, bound on waits
	task end_sim;
		if (fails == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			fails++;
			$display("wrong value at %0t: got %h, expected %h", $time, s, e);
		end
	endtask
	task tmo(input int k);
		if (k >= 300) begin
			fails++;
			end_sim;
		end
	endtask

	// one register access, read data masked by m
	task axi(input bit wr, input logic [7:0] ad, input logic [31:0] dt, e, m,
		input logic [1:0] er);
		int k;
		@(posedge aclk);
		s_axi_awaddr <= ad;
		s_axi_araddr <= ad;
		s_axi_wdata <= dt;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
		{s_axi_arvalid, s_axi_rready} <= {2{!wr}};
		for (k = 0; k < 300; k++) begin
			@(posedge aclk);
			if ((wr ? s_axi_bvalid : s_axi_rvalid) === 1'b1) break;
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end
		tmo(k);
		{s_axi_bready, s_axi_rready} <= 2'h0;
		chk(wr ? s_axi_bresp : s_axi_rresp, er);
		chk(wr ? 32'h0 : s_axi_rdata & m, e);
	endtask

	// one core access; waited counts cycles before the grant
	task core(input bit dp, input logic [31:0] ad, wd, input logic [3:0] be,
		input logic wr, input logic [31:0] ed, input logic ee);
		@(posedge aclk);
		i_addr <= ad;
		d_cmd <= '{ad, wd, be, wr};
		i_req <= !dp;
		d_req <= dp;
		#1;
		for (waited = 0; waited < 300; waited++) begin
			if ((dp ? d_gnt : i_gnt) === 1'b1) break;
			@(posedge aclk);
			#1;
		end
		tmo(waited);
		@(posedge aclk);
		{i_req, d_req} <= 2'h0;
		#1;
		rsp = dp ? d_rsp : i_rsp;
		chk(rsp.valid, 1'b1);
		if (!wr) chk(rsp.data, ed);
		chk(rsp.exc, ee);
	endtask

	// next bus cycle address, then wait for it to end
	task nextbus(input logic [31:0] ad);
		int k;
		for (k = 0; k < 300 && ext_valid !== 1'b1; k++) @(posedge aclk);
		tmo(k);
		chk(ext_cmd.addr, ad);
		wd_seen = ext_cmd.wdata;
		for (k = 0; k < 300 && ext_valid !== 1'b0; k++) @(posedge aclk);
		tmo(k);
	endtask

	// main sequence
	initial begin
		seed = 32'h635da8f5;
		{aresetn, i_req, d_req, ext_breq, s_axi_awvalid, s_axi_wvalid, s_axi_bready,
			s_axi_arvalid, s_axi_rready, i_addr, d_cmd, s_axi_awaddr, s_axi_araddr,
			s_axi_wdata, ws, fails, samples_checked} = '0;
		s_axi_wstrb = 4'hF;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		axi(0, 8'h00, 0, 0, '1, ok);
		axi(0, 8'h04, 0, 0, '1, ok);
		axi(1, 8'h10, 32'hFF, 0, 0, de);
		axi(0, 8'h10, 0, 0, '1, de);
		fork
			core(0, ia, 0, 0, 0, ~ia, 0);
			begin
				ext_breq <= 1'b1;
				repeat (4) @(posedge aclk) chk(ext_valid, 0);
				chk(ext_bgnt, 1);
				ext_breq <= 1'b0;
			end
		join
		repeat (4) @(posedge aclk) chk(ext_valid, 0);
		axi(1, 8'h00, 32'h1, 0, 0, ok);
		core(0, ib, 0, 0, 0, ~ib, 0);
		nextbus(ib + 4);
		core(0, ib, 0, 0, 0, ~ib, 0);
		chk(waited, 0);
		repeat (4) @(posedge aclk) chk(ext_valid, 0);
		core(0, ib + 4, 0, 0, 0, ~(ib + 4), 0);
		nextbus(ib + 8);
		core(0, ic, 0, 0, 0, ~ic, 0);
		core(0, ic + 8, 0, 0, 0, ~(ic + 8), 0);
		chk(waited > 0, 1);
		nextbus(ic + 12);
		core(0, fa, 0, 0, 0, ~fa, 1);
		nextbus(fa + 4);
		core(0, fa + 4, 0, 0, 0, ~(fa + 4), 1);
		core(0, ib, 0, 0, 0, ~ib, 0);
		axi(1, 8'h00, 32'h3, 0, 0, ok);
		core(1, da, 0, 0, 0, ~da, 0);
		core(1, da, 0, 0, 0, ~da, 0);
		chk(waited, 0);
		core(1, fa, 0, 0, 0, ~fa, 1);
		core(1, da, 32'hAB, 4'h1, 1, 0, 0);
		core(1, da, 0, 0, 0, {~da[31:8], 8'hAB}, 0);
		axi(1, 8'h00, 32'h0, 0, 0, ok);
		axi(1, 8'h00, 32'h20, 0, 0, ok);
		axi(1, 8'h00, 32'h21, 0, 0, ok);
		core(1, da + 16, 32'h1234, 4'hF, 1, 0, 0);
		chk(waited > 0, 1);
		axi(1, 8'h00, 32'h23, 0, 0, ok);
		core(1, da + 20, 32'h5678, 4'hF, 1, 0, 0);
		chk(waited, 0);
		nextbus(da + 20);
		chk(wd_seen, 32'h5678);
		ws <= 2'h3;
		for (n = 0; n < 3; n++) core(1, da + 24 + 4 * n, n, 4'hF, 1, 0, 0);
		chk(waited > 0, 1);
		ws <= 2'h0;
		core(1, fa + 16, 32'hDEAD, 4'hF, 1, 0, 0);
		for (n = 0; n < 300 && d_post_exc !== 1'b1; n++) @(posedge aclk);
		chk(n < 300, 1);
		axi(0, 8'h04, 0, 1, 1, ok);
		axi(0, 8'h08, 0, fa + 16, '1, ok);
		axi(1, 8'h04, 1, 0, 0, ok);
		axi(0, 8'h04, 0, 0, 1, ok);
		for (n = 0; n < 12; n++) begin
			a = 32'h800 | (32'($random(seed)) & 32'h7FC);
			ws <= 2'($random(seed));
			core(1, a, 0, 0, 0, ~a, 0);
		end
		end_sim;
	end
endmodule
